// ---- src/i2cec_map.svh ----
// register offsets, field positions, reset values and timing counts of the i2c enable/control block
// assumes inclusion by bare name from the package and the design modules
`ifndef I2CEC_MAP_SVH
`define I2CEC_MAP_SVH

// register offsets (byte addresses)
`define I2CEC_CTRL_OFS       8'h00
`define I2CEC_SETUP_OFS      8'h04
`define I2CEC_STAT_OFS       8'h08
`define I2CEC_MASK_OFS       8'h0c
`define I2CEC_EVT_OFS        8'h10

// control register fields
`define I2CEC_PE_BIT         0
`define I2CEC_TRANSMIT_IRQ_ENABLE_BIT       1
`define I2CEC_RECEIVE_IRQ_ENABLE_BIT       2

// status and event fields
`define I2CEC_EV_RX_BIT      0
`define I2CEC_EV_TX_BIT      1
`define I2CEC_EV_START_BIT   2
`define I2CEC_EV_STOP_BIT    3

// setup register fields
`define I2CEC_SETUP_RESET    32'h0000_0000
`define I2CEC_SETUP_RW_MASK  32'h07ff_ffff

// timing
`define I2CEC_PE_LOW_MIN     3
`define I2CEC_BUS_SYNC_CYC   2
`define I2CEC_KER_SYNC_CYC   6
`define I2CEC_SETUP_BUSY_CYC (`I2CEC_BUS_SYNC_CYC + `I2CEC_KER_SYNC_CYC)

`endif

// ---- src/i2cec_pkg.sv ----
// types of the i2c enable/control block
// assumes the map header is on the include path
`include "i2cec_map.svh"

package i2cec_pkg;
    typedef enum logic [1:0] {
        I2CEC_IDLE  = 2'b00,
        I2CEC_START = 2'b01,
        I2CEC_BUSY  = 2'b11
    } i2cec_bus_t;
endpackage

// ---- src/i2cec_setup_sync.sv ----
// transfer of setup register writes into the controller core, with its busy window
// assumes one clock mclk; kernel-domain latency is modelled as a fixed cycle count
`timescale 1ns/1ps
`default_nettype none
`include "i2cec_map.svh"

module i2cec_setup_sync
    import i2cec_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        clr,
    // write request
    input  wire logic        wr_req,
    input  wire logic [31:0] wr_data,
    // applied value
    output logic             busy,
    output logic [31:0]      setup
);
    logic [3:0]  cnt;
    logic [31:0] pend;

    // count down the transfer window; apply the value at its end
    always_ff @(posedge mclk) begin
        if (sys_rst || clr) begin
            cnt   <= 4'h0;
            pend  <= `I2CEC_SETUP_RESET;
            setup <= `I2CEC_SETUP_RESET;
        end else if (wr_req && cnt == 4'h0) begin
            cnt  <= 4'(`I2CEC_SETUP_BUSY_CYC);
            pend <= wr_data & `I2CEC_SETUP_RW_MASK;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1) begin
                setup <= pend;
            end
        end
    end

    assign busy = (cnt != 4'h0);
endmodule

`default_nettype wire

// ---- src/i2cec_top.sv ----
// enable, interrupt enable and setup-register access logic of an i2c controller
// assumes a plain register port on mclk and open-drain scl/sda pins from outside the domain
`timescale 1ns/1ps
`default_nettype none
`include "i2cec_map.svh"

// How it works
// R1: with the receive interrupt enable set, a receive-buffer-not-empty event raises the interrupt, else it is held back.
// R2: with the transmit interrupt enable set, a transmit-status event raises the interrupt, else it is held back.
// R3: while the peripheral enable is clear, scl and sda are released and never driven.
// R4: clearing the peripheral enable returns all state machines and status bits to reset values.
// R5: software keeps the peripheral enable clear for at least 3 bus clocks before setting it again.
// R6: setup register writes take no wait, except a write during a pending one, which stalls until it ends.
// R7: interrupt enables only gate the request; the status flags keep updating regardless.
module i2cec_top
    import i2cec_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    output logic             reg_wait,
    // core events
    input  wire logic        rx_data_valid,
    input  wire logic        tx_data_taken,
    // scl pin
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe_n,
    // sda pin
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    // interrupt and setup
    output logic             irq,
    output logic [31:0]      transfer_setup
);
    logic              peripheral_enable;
    logic              transmit_irq_enable;
    logic              receive_irq_enable;
    logic [3:0]        status;
    logic [3:0]        mask;
    logic              receive_buffer_not_empty;
    logic              transmit_interrupt_status;
    logic [1:0]        scl_sync;
    logic [1:0]        sda_sync;
    logic              scl_d;
    logic              sda_d;
    logic              pe_clr;
    logic              setup_busy;
    logic              setup_wr;
    logic              held_wr;
    logic [31:0]       held_data;
    i2cec_bus_t        bus_state;
    i2cec_bus_t        next_bus_state;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // control register; a clearing write resets the core below
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            peripheral_enable   <= 1'b0;
            transmit_irq_enable <= 1'b0;
            receive_irq_enable  <= 1'b0;
        end else if (reg_wr && hit(reg_addr, `I2CEC_CTRL_OFS)) begin
            peripheral_enable   <= reg_wdata[`I2CEC_PE_BIT];
            transmit_irq_enable <= reg_wdata[`I2CEC_TRANSMIT_IRQ_ENABLE_BIT];
            receive_irq_enable  <= reg_wdata[`I2CEC_RECEIVE_IRQ_ENABLE_BIT];
        end
    end

    // software must hold the enable low 3 clocks before re-setting it [R5]
    assign pe_clr = ~peripheral_enable; // core held in reset while disabled [R4]

    // pin synchronisers
    // scl_d and sda_d are one cycle older copies: sda_d for edge detection, scl_d for the two-sample scl high check
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            scl_sync <= 2'b11;
            sda_sync <= 2'b11;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_d    <= scl_sync[1];
            sda_d    <= sda_sync[1];
        end
    end

    // bus activity watcher: start and stop conditions
    // scl must be high for two samples so a data change at the scl rise is not taken as a condition
    always_comb begin
        next_bus_state = bus_state;
        case (bus_state)
            I2CEC_IDLE: begin
                if (scl_d && scl_sync[1] && sda_d && !sda_sync[1]) next_bus_state = I2CEC_START;
            end
            I2CEC_START: next_bus_state = I2CEC_BUSY;
            I2CEC_BUSY: begin
                if (scl_d && scl_sync[1] && !sda_d && sda_sync[1]) next_bus_state = I2CEC_IDLE;
            end
            default: next_bus_state = I2CEC_IDLE;
        endcase
    end

    // watcher state; held idle while the peripheral is disabled
    always_ff @(posedge mclk) begin
        if (sys_rst || pe_clr) begin
            bus_state <= I2CEC_IDLE; // [R4]
        end else begin
            bus_state <= next_bus_state;
        end
    end

    // data flags, updated regardless of interrupt enables [R7]
    always_ff @(posedge mclk) begin
        if (sys_rst || pe_clr) begin
            receive_buffer_not_empty  <= 1'b0; // [R4]
            transmit_interrupt_status <= 1'b0;
        end else begin
            if (rx_data_valid) begin
                receive_buffer_not_empty <= 1'b1;
            end else if (reg_rd && hit(reg_addr, `I2CEC_EVT_OFS)) begin
                receive_buffer_not_empty <= 1'b0;
            end
            if (tx_data_taken) begin
                transmit_interrupt_status <= 1'b1;
            end else if (reg_wr && hit(reg_addr, `I2CEC_EVT_OFS)) begin
                transmit_interrupt_status <= 1'b0;
            end
        end
    end

    // sticky status: set wins over read clear
    always_ff @(posedge mclk) begin
        if (sys_rst || pe_clr) begin
            status <= 4'h0; // [R4]
        end else begin
            status <= (reg_rd && hit(reg_addr, `I2CEC_STAT_OFS) ? 4'h0 : status)
                    | {bus_state == I2CEC_BUSY && next_bus_state == I2CEC_IDLE,
                       next_bus_state == I2CEC_START,
                       tx_data_taken,
                       rx_data_valid};
        end
    end

    // mask register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mask <= 4'h0;
        end else if (reg_wr && hit(reg_addr, `I2CEC_MASK_OFS)) begin
            mask <= reg_wdata[3:0];
        end
    end

    // interrupt: data events gated by their enables, all by mask
    assign irq = |(status & mask & {2'b11,
                                    transmit_irq_enable,  // [R2]
                                    receive_irq_enable}); // [R1]

    // setup writes: one pending at a time; a second is held with the bus stalled [R6]
    assign setup_wr = (reg_wr && hit(reg_addr, `I2CEC_SETUP_OFS)) || held_wr;
    assign reg_wait = held_wr; // reg_wait stays raised for as long as a setup write is held

    // a write landing on the release cycle of a held one becomes the new held value, so none is lost
    always_ff @(posedge mclk) begin
        if (sys_rst || pe_clr) begin
            held_wr   <= 1'b0;
            held_data <= 32'h0000_0000;
        end else if (reg_wr && hit(reg_addr, `I2CEC_SETUP_OFS) && (setup_busy || held_wr)) begin
            held_wr   <= 1'b1; // [R6]
            held_data <= reg_wdata;
        end else if (held_wr && !setup_busy) begin
            held_wr <= 1'b0;
        end
    end

    i2cec_setup_sync u_setup (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .clr     (pe_clr),
        .wr_req  (setup_wr),
        .wr_data (held_wr ? held_data : reg_wdata),
        .busy    (setup_busy),
        .setup   (transfer_setup)
    );

    // read data, one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            // unmapped offsets read as zero
            case (reg_addr)
                `I2CEC_CTRL_OFS:  reg_rdata <= {29'h0, receive_irq_enable, transmit_irq_enable, peripheral_enable};
                `I2CEC_SETUP_OFS: reg_rdata <= transfer_setup;
                `I2CEC_STAT_OFS:  reg_rdata <= {28'h0, status};
                `I2CEC_MASK_OFS:  reg_rdata <= {28'h0, mask};
                `I2CEC_EVT_OFS:   reg_rdata <= {28'h0, bus_state == I2CEC_BUSY, setup_busy,
                                                transmit_interrupt_status, receive_buffer_not_empty};
                default:          reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // pins released while disabled; this slice never pulls them low [R3]
    assign scl_out  = 1'b0;
    assign sda_out  = 1'b0;
    assign scl_oe_n = 1'b1;
    assign sda_oe_n = 1'b1;
endmodule

`default_nettype wire

// ---- verif/i2cec_checker.sv ----
// assertions of the i2c enable/control block
// assumes binding to i2cec_top on the single clock mclk
`timescale 1ns/1ps
`default_nettype none
module i2cec_checker (
    // clock, reset and register port
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_wait,
    // events, pins and results
    input wire logic        rx_data_valid,
    input wire logic        tx_data_taken,
    input wire logic        scl_oe_n,
    input wire logic        sda_oe_n,
    input wire logic        irq,
    input wire logic [31:0] transfer_setup
);
    logic [2:0] ctrl;
    logic [3:0] msk;
    logic [4:0] quiet;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // shadow of enables and mask; quiet counts cycles since the last setup write
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl  <= 3'h0;
            msk   <= 4'h0;
            quiet <= 5'h0;
        end else begin
            if (reg_wr && reg_addr == 8'h00) ctrl <= reg_wdata[2:0];
            if (reg_wr && reg_addr == 8'h0c) msk <= reg_wdata[3:0];
            if (reg_wr && reg_addr == 8'h04) quiet <= 5'h0;
            else if (quiet != 5'h1f) quiet <= quiet + 5'h1;
        end
    end
    scl_release_a: assert property (!ctrl[0] |-> scl_oe_n) else $error("scl driven");
    sda_release_a: assert property (!ctrl[0] |-> sda_oe_n) else $error("sda driven");
    rx_irq_a: assert property (ctrl == 3'h5 && msk[0] && rx_data_valid && !reg_wr |=> irq)
        else $error("rx irq missing");
    tx_irq_a: assert property (ctrl == 3'h3 && msk[1] && tx_data_taken && !reg_wr |=> irq)
        else $error("tx irq missing");
    irq_gate_a: assert property (irq |-> ctrl[0] &&
        ((ctrl[2] && msk[0]) || (ctrl[1] && msk[1]) || msk[3:2] != 2'h0)) else $error("irq not gated");
    disable_clear_a: assert property (reg_wr && reg_addr == 8'h00 && !reg_wdata[0]
        |=> ##1 (transfer_setup == 32'h0 && !irq)[*3]) else $error("state kept");
    setup_apply_a: assert property (@(posedge mclk) disable iff (sys_rst || !ctrl[0])
        ctrl[0] && quiet == 5'h1f && reg_wr && reg_addr == 8'h04 |-> !reg_wait
        ##9 transfer_setup == ($past(reg_wdata, 9) & 32'h07ff_ffff)) else $error("setup late");
    wait_bound_a: assert property (reg_wait |-> ##[1:8] !reg_wait) else $error("stall too long");
endmodule
bind i2cec_top i2cec_checker chk (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_wait(reg_wait), .rx_data_valid(rx_data_valid), .tx_data_taken(tx_data_taken),
    .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .irq(irq), .transfer_setup(transfer_setup));
`default_nettype wire

// ---- verif/i2cec_bus_dev.sv ----
// other device on the i2c bus: sends one frame per request
// assumes pull-ups, so a released line reads high
`timescale 1ns/1ps
`default_nettype none
module i2cec_bus_dev (
    // frame request
    input  wire logic start,
    // open-drain lines
    output logic      scl,
    output logic      sda
);
    // start, nine clocks of 320 ns (the ninth takes sda low), stop; scl stands high between frames
    // edges sit 10 ns off the request so they never meet a sampling edge; sda moves mid scl-low
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    always @(posedge start) begin
        #10 sda = 1'b0;
        for (int i = 0; i < 8; i++) begin
            #160 scl = 1'b0;
            #80 sda = i[0];
            #80 scl = 1'b1;
        end
        #160 scl = 1'b0;
        #80 sda = 1'b0;
        #80 scl = 1'b1;
        #160 sda = 1'b1;
    end
endmodule
`default_nettype wire

// ---- verif/i2c_enable_and_control_access_tb_top.sv ----
// self-checking bench of the i2c enable/control block
// assumes design, checker and bus device are compiled before it
`timescale 1ns/1ps
`default_nettype none
module i2c_enable_and_control_access_tb_top;
    logic        mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, frame = 1'b0;
    logic        rx_data_valid = 1'b0, tx_data_taken = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, d, exp_q[$];
    wire  logic  [31:0] reg_rdata, transfer_setup;
    wire  logic  reg_wait, scl_out, scl_oe_n, sda_out, sda_oe_n, irq, dev_scl, dev_sda, scl_in, sda_in;
    integer      failures = 0, comparisons = 0, seed = 32'h3fc7;
    // bus wires: pull-up and open-drain of both parties
    assign scl_in = dev_scl & (scl_oe_n | scl_out);
    assign sda_in = dev_sda & (sda_oe_n | sda_out);
    always #20 mclk = ~mclk;
    i2cec_top dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_wait(reg_wait), .rx_data_valid(rx_data_valid),
        .tx_data_taken(tx_data_taken), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq), .transfer_setup(transfer_setup));
    i2cec_bus_dev bus (.start(frame), .scl(dev_scl), .sda(dev_sda));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk("rdata", reg_rdata, e);
    endtask
    task automatic pulse(input logic rx);
        @(posedge mclk);
        rx_data_valid <= rx;
        tx_data_taken <= !rx;
        @(posedge mclk);
        rx_data_valid <= 1'b0;
        tx_data_taken <= 1'b0;
        #1;
    endtask
    task automatic finish_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // watchdog
    initial begin
        #200000;
        failures++;
        finish_test;
    end
    // main sequence
    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 6; i++) rd(8'(i * 4), 32'h0);
        wr(8'h00, 32'h5);
        wr(8'h0c, 32'h3);
        pulse(1'b0);
        chk("irq", {31'h0, irq}, 32'h0);
        rd(8'h08, 32'h2);
        pulse(1'b1);
        chk("irq", {31'h0, irq}, 32'h1);
        rd(8'h08, 32'h1);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(8'h00, 32'h3);
        pulse(1'b0);
        chk("irq", {31'h0, irq}, 32'h1);
        rd(8'h08, 32'h2);
        wr(8'h00, 32'h1);
        pulse(1'b1);
        pulse(1'b0);
        chk("irq", {31'h0, irq}, 32'h0);
        rd(8'h10, 32'h3);
        for (int i = 0; i < 2; i++) begin
            d = $random(seed);
            exp_q.push_back(d & 32'h07ff_ffff);
            wr(8'h04, d);
        end
        #1 chk("wait", {31'h0, reg_wait}, 32'h1);
        repeat (7) @(posedge mclk);
        #1 chk("setup", transfer_setup, exp_q.pop_front());
        repeat (11) @(posedge mclk);
        #1 chk("setup", transfer_setup, exp_q[0]);
        rd(8'h04, exp_q.pop_front());
        pulse(1'b1);
        wr(8'h00, 32'h0);
        repeat (3) @(posedge mclk);
        #1 chk("pins", {30'h0, scl_oe_n, sda_oe_n}, 32'h3);
        rd(8'h08, 32'h0);
        rd(8'h04, 32'h0);
        wr(8'h00, 32'h1);
        frame <= 1'b1;
        #4000 chk("pins", {30'h0, scl_oe_n, sda_oe_n}, 32'h3);
        rd(8'h08, 32'hc);
        finish_test;
    end
endmodule
`default_nettype wire
